// *** src/msbi_map.svh ***
// constants of the multiplexed system bus interface
// assumes inclusion by the package and by every design file
`ifndef MSBI_MAP_SVH
`define MSBI_MAP_SVH
`define MSBI_AD_MSB     31
`define MSBI_AD_HI_LSB  4
`define MSBI_SZ_MSB     3
`define MSBI_SZ_16B     4'h0
`define MSBI_SZ_4B      4'h4
`define MSBI_BYTES_16   5'h10
`define MSBI_PW_8       2'h0
`define MSBI_PW_16      2'h1
`define MSBI_PW_32      2'h2
`define MSBI_PW_RSVD    2'h3
`define MSBI_LANES_NONE 4'hF
`define MSBI_LANES_ALL  4'hF
`define MSBI_ONE_BYTE   5'h01
`define MSBI_BEAT_ONE   5'h01
`define MSBI_RBUF_DEPTH 16
`define MSBI_WORD_ZERO  32'h0000_0000
`endif

// *** src/msbi_pkg.sv ***
// types of the multiplexed system bus interface
// assumes nothing beyond the constants header
`include "msbi_map.svh"
package msbi_pkg;
    typedef logic [3:0] msbi_size_type;
    typedef logic [1:0] msbi_pw_type;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WLOAD,
        ST_DATA
    } msbi_state_type;
endpackage : msbi_pkg

// *** src/msbi_beat_cnt.sv ***
// beat counter: number of data beats of a transaction and the current beat
// assumes load and advance never come in the same cycle
`include "msbi_map.svh"
module msbi_beat_cnt (
    input  logic                   clk_sys,
    input  logic                   rst,
    input  logic                   load,
    input  logic                   advance,
    input  msbi_pkg::msbi_size_type size,
    input  msbi_pkg::msbi_pw_type   width,
    output logic                   beat_last,
    output logic [4:0]             beat_idx
);
    import msbi_pkg::*;

    logic [4:0] remain_q;
    logic [4:0] remain_d;
    logic [4:0] idx_q;
    logic [4:0] idx_d;

    // beats = bytes divided by port bytes, rounded up
    function automatic logic [4:0] beat_count(input msbi_size_type sz, input msbi_pw_type pw);
        logic [5:0] bytes;
        logic [5:0] round;
        bytes = (sz == `MSBI_SZ_16B) ? {1'b0, `MSBI_BYTES_16} : {2'b00, sz};
        round = bytes + ((6'h01 << pw) - 6'h01);
        beat_count = 5'(round >> pw);
    endfunction : beat_count

    always_comb begin
        remain_d = remain_q;
        idx_d    = idx_q;
        if (load) begin
            remain_d = beat_count(size, width);
            idx_d    = 5'h00;
        end else if (advance) begin
            remain_d = remain_q - `MSBI_BEAT_ONE;
            idx_d    = idx_q + `MSBI_BEAT_ONE;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            remain_q <= 5'h00;
            idx_q    <= 5'h00;
        end else begin
            remain_q <= remain_d;
            idx_q    <= idx_d;
        end
    end

    assign beat_last = (remain_q == `MSBI_BEAT_ONE);
    assign beat_idx  = idx_q;
endmodule : msbi_beat_cnt

// *** src/msbi_top.sv ***
// multiplexed address/data system bus interface, processor side
// assumes ack_n and ad_in come from the board and are asynchronous to clk_sys
// assumes the memory system pulses ack_n low once per data beat
// Notes on behaviour
// - upper bus lines carry address then data; top line is address MSB
// - latch strobe brackets address phase; address valid strobe is its inverse
// - cycle active asserted from address phase until last beat acknowledged
// - fetch output high for instruction fetches, low for data moves
// - read output low for the whole of a read transaction
// - store output low for the whole of a write transaction
// - data phase output low after address cycle until last data cycle ends
// - direction high while device drives data, low while it receives
// - memory acknowledges reads with valid data; device captures into read buffer
// - final beat output low during the last data transfer
`include "msbi_map.svh"
module msbi_top #(
    parameter int RBUF_DEPTH = `MSBI_RBUF_DEPTH
) (
    input  logic                    clk_sys,
    input  logic                    rst,
    input  logic                    req_valid,
    output logic                    req_ready,
    input  logic [31:0]             req_addr,
    input  logic                    req_write,
    input  logic                    req_fetch,
    input  msbi_pkg::msbi_size_type req_size,
    input  msbi_pkg::msbi_pw_type   req_port_width,
    output logic                    req_error,
    input  logic                    wr_valid,
    input  logic [31:0]             wr_data,
    output logic                    wr_ready,
    output logic                    rd_valid,
    output logic [31:0]             rd_data,
    output logic [4:0]              rd_beat,
    output logic                    done,
    input  logic [3:0]              buf_raddr,
    output logic [31:0]             buf_rdata,
    input  logic [31:0]             ad_in,
    output logic [31:0]             ad_out,
    output logic                    ad_oe,
    output logic [1:0]              word_addr,
    output logic                    ale,
    output logic                    address_valid_n,
    output logic                    cycle_active_n,
    output logic                    inst_fetch,
    output logic                    read_n,
    output logic                    store_n,
    output logic                    data_phase_n,
    output logic                    bus_direction,
    input  logic                    ack_n,
    output logic                    final_beat_n,
    output msbi_pkg::msbi_pw_type   port_width,
    output logic [3:0]              lane_select_n
);
    import msbi_pkg::*;

    generate
        if (RBUF_DEPTH < `MSBI_RBUF_DEPTH) begin : g_depth_check
            $error("read buffer too small for sixteen beats");
        end
    endgenerate

    // pin synchronisers
    logic        ack_s1_q;
    logic        ack_s2_q;
    logic        ack_s3_q;
    logic [31:0] ad_s1_q;
    logic [31:0] ad_s2_q;
    logic        ack_fall;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_s1_q <= 1'b1;
            ack_s2_q <= 1'b1;
            ack_s3_q <= 1'b1;
            ad_s1_q  <= `MSBI_WORD_ZERO;
            ad_s2_q  <= `MSBI_WORD_ZERO;
        end else begin
            ack_s1_q <= ack_n;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            ad_s1_q  <= ad_in;
            ad_s2_q  <= ad_s1_q;
        end
    end

    // one sample per acknowledge, even if it is held low
    assign ack_fall = !ack_s2_q && ack_s3_q;

    // transaction state
    msbi_state_type state_q;
    msbi_state_type state_d;
    logic [31:0]    addr_q;
    logic [31:0]    addr_d;
    logic           write_q;
    logic           write_d;
    logic           fetch_q;
    logic           fetch_d;
    msbi_size_type  size_q;
    msbi_size_type  size_d;
    msbi_pw_type    pw_q;
    msbi_pw_type    pw_d;
    logic [31:0]    wdata_q;
    logic [31:0]    wdata_d;
    logic [31:0]    ad_out_q;
    logic [31:0]    ad_out_d;
    logic           err_q;
    logic           err_d;
    logic           done_q;
    logic           done_d;
    logic           rd_valid_q;
    logic           rd_valid_d;
    logic [31:0]    rd_data_q;
    logic [31:0]    rd_data_d;
    logic [4:0]     rd_beat_q;
    logic [4:0]     rd_beat_d;
    logic           cnt_load;
    logic           cnt_adv;
    logic           beat_last;
    logic [4:0]     beat_idx;
    logic           rbuf_we;
    logic [31:0]    rbuf [RBUF_DEPTH];
    logic [31:0]    buf_rdata_q;

    function automatic logic [5:0] port_bytes(input msbi_pw_type pw);
        port_bytes = 6'h01 << pw;
    endfunction : port_bytes

    function automatic logic size_ok(input msbi_size_type sz, input msbi_pw_type pw);
        size_ok = (sz <= `MSBI_SZ_4B) && (pw != `MSBI_PW_RSVD);
    endfunction : size_ok

    // active-low lane selects for the current beat address
    function automatic logic [3:0] lanes_n(input msbi_pw_type pw, input msbi_size_type sz,
                                           input logic [1:0] a);
        logic [7:0] m8;
        logic       lo_used;
        logic       hi_used;
        m8      = 8'h00;
        lo_used = !a[0];
        hi_used = a[0] || (sz != `MSBI_SZ_4B - 4'h3);
        lanes_n = `MSBI_LANES_NONE;
        case (pw)
            `MSBI_PW_32: begin
                if (sz == `MSBI_SZ_16B) begin
                    lanes_n = ~`MSBI_LANES_ALL;
                end else begin
                    m8      = (8'h0F >> (3'h4 - 3'(sz))) << a;
                    lanes_n = ~m8[3:0];
                end
            end
            `MSBI_PW_16: begin
                lanes_n = {!hi_used, 1'b1, a[1], !lo_used};
            end
            `MSBI_PW_8: begin
                lanes_n = {1'b1, 1'b1, a[1], a[0]};
            end
            default: begin
                lanes_n = `MSBI_LANES_NONE;
            end
        endcase
    endfunction : lanes_n

    msbi_beat_cnt u_beat_cnt (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .load      (cnt_load),
        .advance   (cnt_adv),
        .size      (size_d),
        .width     (pw_d),
        .beat_last (beat_last),
        .beat_idx  (beat_idx)
    );

    assign req_ready = (state_q == ST_IDLE);
    assign wr_ready  = (state_q == ST_WLOAD);

    always_comb begin
        state_d    = state_q;
        addr_d     = addr_q;
        write_d    = write_q;
        fetch_d    = fetch_q;
        size_d     = size_q;
        pw_d       = pw_q;
        wdata_d    = wdata_q;
        err_d      = 1'b0;
        done_d     = 1'b0;
        rd_valid_d = 1'b0;
        rd_data_d  = rd_data_q;
        rd_beat_d  = rd_beat_q;
        cnt_load   = 1'b0;
        cnt_adv    = 1'b0;
        rbuf_we    = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (req_valid) begin
                    if (size_ok(req_size, req_port_width)) begin
                        addr_d   = req_addr;
                        write_d  = req_write;
                        fetch_d  = req_fetch;
                        size_d   = req_size;
                        pw_d     = req_port_width;
                        cnt_load = 1'b1;
                        state_d  = ST_ADDR;
                    end else begin
                        err_d = 1'b1;
                    end
                end
            end
            ST_ADDR: begin
                state_d = write_q ? ST_WLOAD : ST_DATA;
            end
            ST_WLOAD: begin
                if (wr_valid) begin
                    wdata_d = wr_data;
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (ack_fall) begin
                    cnt_adv = 1'b1;
                    if (!write_q) begin
                        rd_valid_d = 1'b1;
                        rd_data_d  = ad_s2_q;
                        rd_beat_d  = beat_idx;
                        rbuf_we    = 1'b1;
                    end
                    if (beat_last) begin
                        done_d  = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        addr_d  = addr_q + 32'(port_bytes(pw_q));
                        state_d = write_q ? ST_WLOAD : ST_DATA;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // address then data on the multiplexed lines
    always_comb begin
        ad_out_d = wdata_d;
        if (state_d == ST_ADDR) begin
            // size code on the low lines
            ad_out_d = {addr_d[`MSBI_AD_MSB:`MSBI_AD_HI_LSB], size_d};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            addr_q     <= `MSBI_WORD_ZERO;
            write_q    <= 1'b0;
            fetch_q    <= 1'b0;
            size_q     <= `MSBI_SZ_16B;
            pw_q       <= `MSBI_PW_8;
            wdata_q    <= `MSBI_WORD_ZERO;
            ad_out_q   <= `MSBI_WORD_ZERO;
            err_q      <= 1'b0;
            done_q     <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q  <= `MSBI_WORD_ZERO;
            rd_beat_q  <= 5'h00;
        end else begin
            state_q    <= state_d;
            addr_q     <= addr_d;
            write_q    <= write_d;
            fetch_q    <= fetch_d;
            size_q     <= size_d;
            pw_q       <= pw_d;
            wdata_q    <= wdata_d;
            ad_out_q   <= ad_out_d;
            err_q      <= err_d;
            done_q     <= done_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q  <= rd_data_d;
            rd_beat_q  <= rd_beat_d;
        end
    end

    // read buffer, one word per beat
    always_ff @(posedge clk_sys) begin
        if (rbuf_we) begin
            rbuf[beat_idx[3:0]] <= ad_s2_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            buf_rdata_q <= `MSBI_WORD_ZERO;
        end else begin
            buf_rdata_q <= rbuf[buf_raddr];
        end
    end

    // bus strobes decoded from the registered state
    logic in_txn;
    logic in_data;
    assign in_txn  = (state_q != ST_IDLE);
    assign in_data = (state_q == ST_WLOAD) || (state_q == ST_DATA);

    assign ad_out          = ad_out_q;
    assign ad_oe           = (state_q == ST_ADDR) || (in_data && write_q);
    assign ale             = (state_q == ST_ADDR);
    assign address_valid_n = !(state_q == ST_ADDR);
    assign cycle_active_n  = !in_txn;
    assign inst_fetch      = in_txn && fetch_q;
    assign read_n          = !(in_txn && !write_q);
    assign store_n         = !(in_txn && write_q);
    assign data_phase_n    = !in_data;
    assign bus_direction   = in_data && write_q;
    assign final_beat_n    = !(in_data && beat_last);
    assign port_width      = pw_q;
    assign lane_select_n   = in_txn ? lanes_n(pw_q, size_q, addr_q[1:0]) : `MSBI_LANES_NONE;
    assign word_addr       = addr_q[3:2];

    assign req_error = err_q;
    assign done      = done_q;
    assign rd_valid  = rd_valid_q;
    assign rd_data   = rd_data_q;
    assign rd_beat   = rd_beat_q;
    assign buf_rdata = buf_rdata_q;
endmodule : msbi_top

// *** tb/msbi_properties.sv ***
// checker: strobe and phase relations of the multiplexed system bus
// assumes binding to msbi_top, one clock domain
module msbi_properties (
    input logic                    clk_sys,
    input logic                    rst,
    input logic                    req_valid,
    input logic                    req_ready,
    input logic [31:0]             req_addr,
    input logic                    req_write,
    input logic                    req_fetch,
    input msbi_pkg::msbi_size_type req_size,
    input msbi_pkg::msbi_pw_type   req_port_width,
    input logic                    done,
    input logic [31:0]             ad_out,
    input logic                    ad_oe,
    input logic                    ale,
    input logic                    address_valid_n,
    input logic                    cycle_active_n,
    input logic                    inst_fetch,
    input logic                    read_n,
    input logic                    store_n,
    input logic                    data_phase_n,
    input logic                    bus_direction,
    input logic                    ack_n,
    input logic                    final_beat_n,
    input msbi_pkg::msbi_pw_type   port_width
);
    timeunit 1ns;
    timeprecision 1ns;
    import msbi_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_strobe_inverse: assert property (
        address_valid_n == !ale) else $error("address valid not inverse of latch");
    a_take_to_addr: assert property (
        req_valid && req_ready && req_size <= 4'h4 && req_port_width != 2'h3 |=> ale && ad_oe
        && ({4'h0, ad_out[31:4]} == ($past(req_addr) >> 4))) else $error("address phase wrong");
    a_size_width: assert property (
        ale |-> ad_out[3:0] == $past(req_size) && port_width == $past(req_port_width))
        else $error("size or width code wrong");
    a_addr_one_cycle: assert property (
        ale |=> !ale && !data_phase_n && !cycle_active_n) else $error("data phase not entered");
    a_kind_strobes: assert property (
        ale |-> inst_fetch == $past(req_fetch) && read_n == $past(req_write)
        && store_n == !$past(req_write)) else $error("kind strobes wrong");
    a_kind_steady: assert property (
        !cycle_active_n && !ale |-> $stable(read_n) && $stable(store_n) && $stable(inst_fetch))
        else $error("kind strobes moved");
    a_bus_direction: assert property (
        !data_phase_n |-> bus_direction == !store_n && (read_n || !ad_oe))
        else $error("direction wrong");
    a_active_cover: assert property (
        !data_phase_n |-> !cycle_active_n) else $error("cycle not active in data");
    a_read_ack_done: assert property (
        !ack_n && $past(ack_n) && !read_n && !data_phase_n && !final_beat_n |-> ##[2:4] done)
        else $error("last read ack not finished");
    a_done_release: assert property (
        done |-> cycle_active_n && data_phase_n && final_beat_n && !$past(final_beat_n))
        else $error("strobes not released at end");
endmodule : msbi_properties
bind msbi_top msbi_properties u_props (.clk_sys, .rst, .req_valid, .req_ready, .req_addr,
    .req_write, .req_fetch, .req_size, .req_port_width, .done, .ad_out, .ad_oe, .ale,
    .address_valid_n, .cycle_active_n, .inst_fetch, .read_n, .store_n, .data_phase_n,
    .bus_direction, .ack_n, .final_beat_n, .port_width);

// *** tb/msbi_mem_model.sv ***
// memory system model on the multiplexed bus
// assumes one ack pulse per beat, pins sampled 10 ns after the edge
module msbi_mem_model (
    input  logic        clk_sys,
    input  logic        ale,
    input  logic [31:0] ad_out,
    input  logic        data_phase_n,
    input  logic        store_n,
    output logic        ack_n,
    output logic [31:0] ad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] base;
    logic [31:0] wlog [16];
    int          beat;
    initial begin
        ack_n = 1'b1;
        ad_in = 32'h0000_0000;
        beat = 0;
        forever begin
            @(posedge clk_sys);
            #10;
            if (ale) begin
                base = ad_out;
                beat = 0;
            end
            if (!data_phase_n) begin
                repeat (2 + beat % 3) @(posedge clk_sys);
                #10 ad_in = base ^ (32'h1111_1111 * beat);
                @(posedge clk_sys);
                #10 ack_n = 1'b0;
                @(posedge clk_sys);
                #10 ack_n = 1'b1;
                if (!store_n) wlog[beat[3:0]] = ad_out;
                repeat (3) @(posedge clk_sys);
                #10 ad_in = ~ad_in;
                beat = beat + 1;
                // back-to-back address phase lands here
                if (ale) begin
                    base = ad_out;
                    beat = 0;
                end
            end
        end
    end
endmodule : msbi_mem_model

// *** tb/msbi_top_tb.sv ***
// self-checking bench of the multiplexed system bus interface
// assumes the memory model answers every data beat
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module msbi_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst, req_valid, req_write, req_fetch, wr_valid, ack_n, req_ready, req_error;
    logic wr_ready, rd_valid, done, ad_oe, ale, address_valid_n, cycle_active_n, inst_fetch;
    logic read_n, store_n, data_phase_n, bus_direction, final_beat_n;
    logic [31:0] req_addr, wr_data, ad_in, ad_out, rd_data, buf_rdata, lfsr_q;
    logic [3:0]  req_size, buf_raddr, lane_select_n;
    logic [1:0]  req_port_width, word_addr, port_width;
    logic [4:0]  rd_beat;
    int          n_errors, tests_run, cycles, k;
    msbi_top u_dut (.clk_sys, .rst, .req_valid, .req_ready, .req_addr, .req_write, .req_fetch,
        .req_size, .req_port_width, .req_error, .wr_valid, .wr_data, .wr_ready, .rd_valid,
        .rd_data, .rd_beat, .done, .buf_raddr, .buf_rdata, .ad_in, .ad_out, .ad_oe, .word_addr,
        .ale, .address_valid_n, .cycle_active_n, .inst_fetch, .read_n, .store_n, .data_phase_n,
        .bus_direction, .ack_n, .final_beat_n, .port_width, .lane_select_n);
    msbi_mem_model u_mem (.clk_sys, .ale, .ad_out, .data_phase_n, .store_n, .ack_n, .ad_in);
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_step
    function automatic int beats_of(input logic [3:0] sz, input logic [1:0] pw);
        int by;
        by = (sz == 4'h0) ? 16 : int'(sz);
        return (by + (1 << pw) - 1) >> pw;
    endfunction : beats_of
    function automatic logic [3:0] lanes_exp(input logic [3:0] sz, input logic [1:0] pw,
                                             input logic [1:0] a);
        int by;
        by = (sz == 4'h0) ? 16 : int'(sz);
        if (pw == 2'h2) return (by == 16) ? 4'h0 : ~4'(((1 << by) - 1) << a);
        if (pw == 2'h1) return {!a[0] && by == 1, 1'b1, a[1], a[0]};
        return {2'b11, a};
    endfunction : lanes_exp
    task automatic close_out;
        if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic run_txn(input logic [31:0] a, input logic w, input logic f,
                           input logic [3:0] sz, input logic [1:0] pw);
        logic [31:0] base, seed;
        int          nb, ri, wi, cyc;
        logic        took, fin;
        base = {a[31:4], sz};
        seed = ~lfsr_q;
        nb = beats_of(sz, pw);
        {ri, wi, took, fin} = '0;
        {req_addr, req_write, req_fetch, req_size, req_port_width} = {a, w, f, sz, pw};
        wr_data = seed;
        wr_valid = w;
        req_valid = 1'b1;
        @(posedge clk_sys);
        #10 req_valid = 1'b0;
        for (cyc = 0; cyc < 600 && !fin; cyc++) begin
            if (cyc == 0) begin
                `CHK(word_addr, a[3:2])
                `CHK(lane_select_n, lanes_exp(sz, pw, a[1:0]))
            end
            if (took) begin
                wi++;
                wr_data = seed ^ (32'h0303_0303 * wi);
            end
            took = (wr_ready === 1'b1) && w;
            if (rd_valid === 1'b1) begin
                `CHK(rd_data, base ^ (32'h1111_1111 * ri))
                `CHK(rd_beat, 5'(ri))
                ri++;
            end
            fin = (done === 1'b1);
            if (!fin) begin
                @(posedge clk_sys);
                #10;
            end
        end
        `CHK(fin, 1'b1)
        `CHK({cycle_active_n, data_phase_n, read_n, store_n}, 4'hF)
        `CHK(w ? wi : ri, nb)
        for (int i = 0; i < nb; i++) begin
            if (w) `CHK(u_mem.wlog[i], seed ^ (32'h0303_0303 * i))
            else begin
                buf_raddr = 4'(i);
                @(posedge clk_sys);
                #10 `CHK(buf_rdata, base ^ (32'h1111_1111 * i))
            end
        end
    endtask : run_txn
    task automatic refuse(input logic [3:0] sz, input logic [1:0] pw);
        logic seen_err, seen_ale;
        {seen_err, seen_ale} = '0;
        {req_size, req_port_width, req_valid} = {sz, pw, 1'b1};
        @(posedge clk_sys);
        #10 req_valid = 1'b0;
        repeat (3) begin
            seen_err |= (req_error === 1'b1);
            seen_ale |= (ale !== 1'b0);
            @(posedge clk_sys);
            #10;
        end
        `CHK({seen_err, seen_ale}, 2'b10)
    endtask : refuse
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            close_out;
        end
    end
    initial begin
        {rst, req_valid, req_write, req_fetch, wr_valid} = 5'h1F;
        {req_valid, req_write, req_fetch, wr_valid} = '0;
        {req_addr, wr_data, req_size, buf_raddr, req_port_width} = '0;
        {n_errors, tests_run, cycles} = '0;
        lfsr_q = 32'hfe13;
        repeat (12) @(posedge clk_sys);
        #10 rst = 1'b0;
        run_txn(32'h8000_0010, 1'b0, 1'b1, 4'h0, 2'h0);
        run_txn(32'hffff_fff0, 1'b1, 1'b0, 4'h0, 2'h1);
        refuse(4'h5, 2'h2);
        refuse(4'hF, 2'h0);
        refuse(4'h4, 2'h3);
        for (k = 0; k < 40; k++) begin
            lfsr_q = lfsr_step(lfsr_q);
            run_txn(lfsr_q, lfsr_q[0], lfsr_q[1], 4'(int'(lfsr_q[7:4]) % 5),
                    2'(int'(lfsr_q[9:8]) % 3));
        end
        close_out;
    end
endmodule : msbi_top_tb
